// file: design/acr_top.sv
// Purpose: converter control and interrupt enable with AHB-Lite registers
// Assumes: peripheral requests and events come from logic on clk_sys
// Notes:   reads take one wait state, writes none
// Operation
// - on-request mode runs only while requested
// - otherwise runs continuously while enabled
// - standby without run-in-standby halts converter
// - run-in-standby keeps normal mode choice
// - mode bits apply at once, no pending
// - enable takes effect after sync delay
// - enable reads back at once; pending flag
// - writing 0 to enable-clear does nothing
// - writing 1 clears that interrupt enable
// - set and clear share one state
// - enable-clear reads back enable state
// - irq when flag and enable set
// - write protection; enable/reset synchronised
`timescale 1ns/1ps
`default_nettype none
module acr_top (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    input  wire logic                        periph_req,
    input  wire logic                        standby_sleep,
    input  wire logic                        write_protect,
    input  wire acr_pkg::acr_evt_t           evt,
    output logic                             converter_run,
    output logic                             irq
);
    logic                      dp_wr_r;
    logic                      dp_rd_r;
    logic                      rd_done_r;
    logic [11:0]               dp_addr_r;
    logic                      addr_ok;
    acr_pkg::acr_ctrl_t        ctrl_r;
    logic [2:0]                inten_r;
    logic [2:0]                flag_r;
    logic                      en_busy;
    logic                      en_done;
    logic                      en_eff;
    logic                      sr_busy;
    logic                      sr_done;
    logic                      soft_rst_n;
    logic                      wr_ok;
    logic                      wr_ctrl;
    logic                      wr_clr;
    logic                      wr_set;
    logic                      rd_cap;
    logic                      rd_flag;
    logic [2:0]                evt_v;
    logic [31:0]               rd_val;
    logic                      mode_on;

    // soft reset acts like rst_n once its delay has run
    assign soft_rst_n = rst_n && !sr_done;
    assign evt_v      = evt;

    // bus address phase
    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            dp_wr_r   <= 1'b0;
            dp_rd_r   <= 1'b0;
            dp_addr_r <= '0;
        end
        else if (hreadyout)
        begin
            dp_wr_r   <= addr_ok && hwrite;
            dp_rd_r   <= addr_ok && !hwrite;
            dp_addr_r <= addr_ok ? haddr[11:0] : dp_addr_r;
        end
    end

    // one wait state lets a read see the previous write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rd_done_r <= 1'b0;
        end
        else
        begin
            rd_done_r <= dp_rd_r && !rd_done_r;
        end
    end

    assign hreadyout = !(dp_rd_r && !rd_done_r);
    assign hresp     = 1'b0;
    assign rd_cap    = dp_rd_r && !rd_done_r;
    assign rd_flag   = rd_cap && dp_addr_r == acr_pkg::OFS_INTFLAG;

    assign wr_ok   = dp_wr_r && !write_protect && !sr_busy;
    assign wr_ctrl = wr_ok && dp_addr_r == acr_pkg::OFS_CTRL;
    assign wr_clr  = wr_ok && dp_addr_r == acr_pkg::OFS_INTERRUPT_ENABLE_CLEAR;
    assign wr_set  = wr_ok && dp_addr_r == acr_pkg::OFS_INTERRUPT_ENABLE_SET;

    always_ff @(posedge clk_sys)
    begin
        if (!soft_rst_n)
        begin
            ctrl_r <= acr_pkg::acr_ctrl_t'(3'b000);
        end
        else if (wr_ctrl)
        begin
            ctrl_r.on_request_operation <= hwdata[acr_pkg::CTRL_ONREQ];
            ctrl_r.run_in_standby       <= hwdata[acr_pkg::CTRL_STDBY];
            ctrl_r.enable               <= hwdata[acr_pkg::CTRL_ENABLE];
        end
    end

    acr_sync #(
        .DELAY   (acr_pkg::SYNC_CYC)
    ) u_en_sync (
        .clk_sys (clk_sys),
        .rst_n   (soft_rst_n),
        .start   (wr_ctrl && hwdata[acr_pkg::CTRL_ENABLE] != ctrl_r.enable),
        .value   (hwdata[acr_pkg::CTRL_ENABLE]),
        .busy    (en_busy),
        .done    (en_done),
        .out_val (en_eff)
    );

    acr_sync #(
        .DELAY   (acr_pkg::SYNC_CYC)
    ) u_sr_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (wr_ctrl && hwdata[acr_pkg::CTRL_SOFT_RESET_BIT]),
        .value   (1'b1),
        .busy    (sr_busy),
        .done    (sr_done),
        .out_val ()
    );

    always_ff @(posedge clk_sys)
    begin
        if (!soft_rst_n)
        begin
            inten_r <= acr_pkg::INTEN_RST;
        end
        else if (wr_clr)
        begin
            inten_r <= inten_r & ~hwdata[2:0];
        end
        else if (wr_set)
        begin
            inten_r <= inten_r | hwdata[2:0];
        end
    end

    // sticky flags, a read clears them, a new event wins
    always_ff @(posedge clk_sys)
    begin
        if (!soft_rst_n)
        begin
            flag_r <= 3'h0;
        end
        else if (rd_flag)
        begin
            flag_r <= evt_v;
        end
        else
        begin
            flag_r <= flag_r | evt_v;
        end
    end

    assign irq = |(flag_r & inten_r);

    always_comb
    begin
        mode_on = ctrl_r.on_request_operation ? periph_req : 1'b1;
        if (!en_eff)
        begin
            converter_run = 1'b0;
        end
        else if (standby_sleep && !ctrl_r.run_in_standby)
        begin
            converter_run = 1'b0;
        end
        else
        begin
            converter_run = mode_on;
        end
    end

    // read mux
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (dp_addr_r == acr_pkg::OFS_CTRL)
        begin
            rd_val[acr_pkg::CTRL_ONREQ]  = ctrl_r.on_request_operation;
            rd_val[acr_pkg::CTRL_STDBY]  = ctrl_r.run_in_standby;
            rd_val[acr_pkg::CTRL_ENABLE] = ctrl_r.enable;
        end
        else if (dp_addr_r == acr_pkg::OFS_INTERRUPT_ENABLE_CLEAR || dp_addr_r == acr_pkg::OFS_INTERRUPT_ENABLE_SET)
        begin
            rd_val[2:0] = inten_r;
        end
        else if (dp_addr_r == acr_pkg::OFS_INTFLAG)
        begin
            rd_val[2:0] = flag_r;
        end
        else if (dp_addr_r == acr_pkg::OFS_SYNCPEND)
        begin
            rd_val[acr_pkg::SP_ENABLE] = en_busy;
            rd_val[acr_pkg::SP_SOFT_RESET_BIT]  = sr_busy;
        end
        else if (dp_addr_r == acr_pkg::OFS_STATUS)
        begin
            rd_val[acr_pkg::ST_RUN]   = converter_run;
            rd_val[acr_pkg::ST_ENEFF] = en_eff;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_cap)
        begin
            hrdata <= rd_val;
        end
    end

    property p_onreq_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl_r.on_request_operation && !periph_req |-> !converter_run;
    endproperty
    a_onreq_idle: assert property (p_onreq_idle) else $error("runs without request");

    property p_always_on;
        @(posedge clk_sys) disable iff (!rst_n)
        en_eff && !ctrl_r.on_request_operation && !standby_sleep |-> converter_run;
    endproperty
    a_always_on: assert property (p_always_on) else $error("enabled but not running");

    property p_stdby_halt;
        @(posedge clk_sys) disable iff (!rst_n)
        standby_sleep && !ctrl_r.run_in_standby |-> !converter_run;
    endproperty
    a_stdby_halt: assert property (p_stdby_halt) else $error("runs in standby");

    property p_stdby_run;
        @(posedge clk_sys) disable iff (!rst_n)
        standby_sleep && ctrl_r.run_in_standby && en_eff
            && (periph_req || !ctrl_r.on_request_operation) |-> converter_run;
    endproperty
    a_stdby_run: assert property (p_stdby_run) else $error("halted in standby");

    property p_mode_nosync;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        wr_ctrl && hwdata[acr_pkg::CTRL_ENABLE] == ctrl_r.enable
            && !hwdata[acr_pkg::CTRL_SOFT_RESET_BIT] && !en_busy && !sr_busy
            |=> !en_busy && !sr_busy
                && ctrl_r.on_request_operation == $past(hwdata[acr_pkg::CTRL_ONREQ]);
    endproperty
    a_mode_nosync: assert property (p_mode_nosync) else $error("mode bit delayed");

    property p_en_pending;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        wr_ctrl && hwdata[acr_pkg::CTRL_ENABLE] != ctrl_r.enable
            |=> en_busy && ctrl_r.enable == $past(hwdata[acr_pkg::CTRL_ENABLE]);
    endproperty
    a_en_pending: assert property (p_en_pending) else $error("enable pending wrong");

    property p_en_land;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        $fell(en_busy) |-> en_eff == ctrl_r.enable;
    endproperty
    a_en_land: assert property (p_en_land) else $error("enable not applied");

    property p_clr;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        wr_clr |=> inten_r == ($past(inten_r) & ~$past(hwdata[2:0]));
    endproperty
    a_clr: assert property (p_clr) else $error("enable clear wrong");

    property p_rdback;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_cap && dp_addr_r == acr_pkg::OFS_INTERRUPT_ENABLE_CLEAR |=> hrdata[2:0] == $past(inten_r);
    endproperty
    a_rdback: assert property (p_rdback) else $error("enable readback wrong");

    property p_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        (flag_r[acr_pkg::IRQ_WINDOW_MONITOR_IRQ] && inten_r[acr_pkg::IRQ_WINDOW_MONITOR_IRQ]) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_irq_ovr;
        @(posedge clk_sys) disable iff (!rst_n)
        (flag_r[acr_pkg::IRQ_OVERRUN] && inten_r[acr_pkg::IRQ_OVERRUN]) |-> irq;
    endproperty
    a_irq_ovr: assert property (p_irq_ovr) else $error("overrun irq missing");

    property p_irq_res;
        @(posedge clk_sys) disable iff (!rst_n)
        (flag_r[acr_pkg::IRQ_RESULT_READY_IRQ] && inten_r[acr_pkg::IRQ_RESULT_READY_IRQ]) |-> irq;
    endproperty
    a_irq_res: assert property (p_irq_res) else $error("result irq missing");

    property p_set;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        wr_set |=> inten_r == ($past(inten_r) | $past(hwdata[2:0]));
    endproperty
    a_set: assert property (p_set) else $error("enable set wrong");

    property p_wprot;
        @(posedge clk_sys) disable iff (!soft_rst_n)
        dp_wr_r && write_protect |=> $stable(ctrl_r) && $stable(inten_r);
    endproperty
    a_wprot: assert property (p_wprot) else $error("protected write landed");

    property p_soft_reset_bit;
        @(posedge clk_sys) disable iff (!rst_n)
        sr_done |=> ctrl_r == acr_pkg::acr_ctrl_t'(3'b000) && inten_r == acr_pkg::INTEN_RST
            && !sr_busy;
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset incomplete");

endmodule
`default_nettype wire

// file: design/acr_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes:   offsets are byte addresses
package acr_pkg;

    localparam int          DATA_W         = 32;
    localparam int          REG_W          = 8;
    localparam int          IRQ_N          = 3;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_INTERRUPT_ENABLE_CLEAR   = 12'h004;
    localparam logic [11:0] OFS_INTERRUPT_ENABLE_SET   = 12'h008;
    localparam logic [11:0] OFS_INTFLAG    = 12'h00C;
    localparam logic [11:0] OFS_SYNCPEND   = 12'h010;
    localparam logic [11:0] OFS_STATUS     = 12'h014;

    // converter_control fields
    localparam int          CTRL_ONREQ     = 7;
    localparam int          CTRL_STDBY     = 6;
    localparam int          CTRL_ENABLE    = 1;
    localparam int          CTRL_SOFT_RESET_BIT     = 0;

    // sync_pending_flags fields
    localparam int          SP_ENABLE      = 1;
    localparam int          SP_SOFT_RESET_BIT       = 0;

    // interrupt source positions
    localparam int          IRQ_WINDOW_MONITOR_IRQ     = 2;
    localparam int          IRQ_OVERRUN    = 1;
    localparam int          IRQ_RESULT_READY_IRQ     = 0;

    // status fields
    localparam int          ST_RUN         = 0;
    localparam int          ST_ENEFF       = 1;

    // reset values
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [2:0]  INTEN_RST      = 3'h0;

    // synchronisation delay
    localparam int          SYNC_NS        = 75;
    localparam int          CLK_NS         = 25;
    localparam int          SYNC_CYC       = (SYNC_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic window_monitor_irq;
        logic overrun_irq;
        logic result_ready_irq;
    } acr_evt_t;

    typedef struct packed {
        logic on_request_operation;
        logic run_in_standby;
        logic enable;
    } acr_ctrl_t;

endpackage

// file: design/acr_sync.sv
// Purpose: delayed hand-over of one control bit with a pending flag
// Assumes: start is a one-cycle pulse on clk_sys
// Notes:   a new start while pending restarts the delay
`timescale 1ns/1ps
`default_nettype none
module acr_sync #(
    parameter int DELAY = acr_pkg::SYNC_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic value,
    output logic      busy,
    output logic      done,
    output logic      out_val
);
    localparam int CW = $clog2(DELAY + 1);

    generate
        if (DELAY < 1)
        begin : g_chk
            $error("acr_sync DELAY must be at least 1");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic          pend_r;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_r   <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
            pend_r  <= 1'b0;
            out_val <= 1'b0;
        end
        else if (start)
        begin
            cnt_r  <= CW'(DELAY);
            busy   <= 1'b1;
            done   <= 1'b0;
            pend_r <= value;
        end
        else if (busy && cnt_r == CW'(1))
        begin
            cnt_r   <= '0;
            busy    <= 1'b0;
            done    <= 1'b1;
            out_val <= pend_r;
        end
        else
        begin
            cnt_r <= busy ? cnt_r - CW'(1) : cnt_r;
            done  <= 1'b0;
        end
    end

    property p_sync_done;
        @(posedge clk_sys) disable iff (!rst_n)
        start ##1 !start [*1] |-> ##[0:16] (done || start);
    endproperty
    a_sync_done: assert property (p_sync_done) else $error("sync never completed");

endmodule
`default_nettype wire

// file: dv/acr_periph_model.sv
// Purpose: requesting peripheral and event source beside the converter
// Assumes: commands from the bench on clk_sys
// Notes:   slow mode delays the request by one more cycle
`timescale 1ns/1ps
`default_nettype none
module acr_periph_model (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              req_cmd,
    input  wire logic              slow,
    input  wire acr_pkg::acr_evt_t fire_cmd,
    output var logic               periph_req,
    output var acr_pkg::acr_evt_t  evt
);
    logic req_d_r;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            req_d_r    <= 1'b0;
            periph_req <= 1'b0;
            evt        <= '0;
        end
        else
        begin
            req_d_r    <= req_cmd;
            periph_req <= slow ? req_d_r : req_cmd;
            // one-cycle event pulses
            evt        <= fire_cmd;
        end
    end
endmodule
`default_nettype wire

// file: dv/acr_top_tb_top.sv
// Purpose: self-checking bench of the converter control block
// Assumes: one slave on the bus, hready looped from hreadyout
// Notes:   rd results are checked from a queue by a monitor, other reads inline
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module acr_top_tb_top;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              hsel = 1'b0;
    logic [31:0]       haddr = '0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = '0;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic              standby_sleep = 1'b0;
    logic              write_protect = 1'b0;
    logic              req_cmd = 1'b0;
    logic              slow = 1'b0;
    acr_pkg::acr_evt_t fire = '0;
    acr_pkg::acr_evt_t evt;
    logic              periph_req;
    logic              converter_run;
    logic              irq;
    logic [31:0]       exp_q[$];
    logic              rd_ph = 1'b0;
    logic [31:0]       seed = 32'h00005BA7;
    logic [31:0]       v;
    logic [31:0]       exp_v;
    logic [11:0]       rst_ofs [5] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h040};
    logic [2:0]        en;
    logic [2:0]        flg;
    int                miscompares = 0;
    int                checks_done = 0;
    int                cyc = 0;

    acr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .periph_req(periph_req), .standby_sleep(standby_sleep),
        .write_protect(write_protect), .evt(evt), .converter_run(converter_run), .irq(irq));

    acr_periph_model peer (.clk_sys(clk_sys), .rst_n(rst_n), .req_cmd(req_cmd), .slow(slow),
        .fire_cmd(fire), .periph_req(periph_req), .evt(evt));

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one single word transfer, started right after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic chk, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= w;
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        @(posedge clk_sys);
        rd_ph  = chk;
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] t;
        xfer(1'b1, a, d, 1'b0, t);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] t;
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0, 1'b1, t);
    endtask

    task automatic wait_sync();
        logic [31:0] t;
        for (int i = 0; i < 20; i++)
        begin
            xfer(1'b0, acr_pkg::OFS_SYNCPEND, 32'h0, 1'b0, t);
            if (t == 32'h0)
                break;
        end
        `CHK(t, 32'h0)
    endtask

    always @(negedge clk_sys)
    begin
        if (rd_ph && hreadyout === 1'b1)
        begin
            rd_ph = 1'b0;
            // pop once: the compare macro names its expected value twice
            exp_v = exp_q.pop_front();
            `CHK(hresp, 1'b0)
            `CHK(hrdata, exp_v)
        end
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            miscompares++;
            $display("ERROR %0t: run timed out", $time);
            close_out();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rst_ofs[k])
            rd(rst_ofs[k], 32'h0);
        $display("test reset_values done");
        wr(acr_pkg::OFS_CTRL, 32'h02);
        @(negedge clk_sys);
        `CHK(converter_run, 1'b0)
        @(posedge clk_sys);
        // pending flag stands only for the sync delay, so read it first
        xfer(1'b0, acr_pkg::OFS_SYNCPEND, 32'h0, 1'b0, v);
        `CHK(v[acr_pkg::SP_ENABLE], 1'b1)
        rd(acr_pkg::OFS_CTRL, 32'h02);
        wait_sync();
        rd(acr_pkg::OFS_STATUS, 32'h3);
        $display("test enable_sync done");
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            wr(acr_pkg::OFS_CTRL, {24'h0, i[0], i[1], 6'h02});
            standby_sleep <= i[2];
            req_cmd <= i[3];
            slow <= seed[0];
            repeat (3) @(negedge clk_sys);
            `CHK(converter_run, !(i[2] && !i[1]) && (i[0] ? i[3] : 1'b1))
            @(posedge clk_sys);
            rd(acr_pkg::OFS_SYNCPEND, 32'h0);
        end
        $display("test run_modes done");
        en = 3'h7;
        flg = 3'h0;
        wr(acr_pkg::OFS_INTERRUPT_ENABLE_SET, 32'h7);
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            wr(acr_pkg::OFS_INTERRUPT_ENABLE_CLEAR, {29'h0, seed[2:0]});
            en = en & ~seed[2:0];
            rd(acr_pkg::OFS_INTERRUPT_ENABLE_CLEAR, {29'h0, en});
            rd(acr_pkg::OFS_INTERRUPT_ENABLE_SET, {29'h0, en});
            fire <= acr_pkg::acr_evt_t'(seed[6:4]);
            @(posedge clk_sys);
            fire <= '0;
            flg = seed[6:4];
            @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK(irq, |(flg & en))
            @(posedge clk_sys);
            rd(acr_pkg::OFS_INTFLAG, {29'h0, flg});
            @(negedge clk_sys);
            `CHK(irq, 1'b0)
            @(posedge clk_sys);
            wr(acr_pkg::OFS_INTERRUPT_ENABLE_SET, 32'h7);
            en = 3'h7;
        end
        $display("test interrupts done");
        write_protect <= 1'b1;
        // leave standby so clearing run-in-standby cannot stop the converter
        standby_sleep <= 1'b0;
        wr(acr_pkg::OFS_CTRL, 32'h00);
        rd(acr_pkg::OFS_CTRL, 32'hC2);
        write_protect <= 1'b0;
        wr(acr_pkg::OFS_CTRL, 32'h00);
        @(negedge clk_sys);
        `CHK(converter_run, 1'b1)
        @(posedge clk_sys);
        wait_sync();
        @(negedge clk_sys);
        `CHK(converter_run, 1'b0)
        @(posedge clk_sys);
        $display("test protect_disable done");
        wr(acr_pkg::OFS_CTRL, 32'hC2);
        wait_sync();
        wr(acr_pkg::OFS_CTRL, 32'h01);
        wait_sync();
        rd(acr_pkg::OFS_CTRL, 32'h0);
        rd(acr_pkg::OFS_INTERRUPT_ENABLE_SET, 32'h0);
        @(negedge clk_sys);
        `CHK(converter_run, 1'b0)
        $display("test soft_reset done");
        close_out();
    end
endmodule
`default_nettype wire
